/* File: design/pscc_pkg.sv */
/*
 * Constants for the synthesizer control block: register map, field layout,
 * reset values, serial frame format and calibration length.
 * Assumes one system clock; every pin is already synchronous to it.
 */
// What this block does
// - field 0x22[2:0] picks one of four oscillators, codes 000 to 011.
// - bit 15 of 0x02 selects integer or fractional division; fractional after reset.
// - numerator and modulus are each held as 16-bit values.
// - division ratio is integer 0x02 plus numerator 0x03 over modulus 0x04.
// - a fixed divide-by-two prescaler follows the oscillator.
// - field 0x22[5:3] sets output divide 1, 2, 4 or 8.
// - status pin shows lock detect, high while locked, when routed there.
// - field 0x21[14:13] selects status pin source; reset routes lock detect.
// - any write to 0x02, 0x03 or 0x04 starts oscillator band calibration.
// - calibration lasts 5120 comparison cycles, then the loop settles.
// - lock time is calibration followed by analog loop settling.
// - bit 7 of 0x01 enables the differential LO output buffer.
// - field 0x22[7:6] sets four increasing LO output amplitudes.
// - reference clock is divided by 1 to 8191 to form comparison clock.
`default_nettype none
package pscc_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 16;
	localparam int HDR_BITS = 8;
	localparam int FRAME_BITS = 24;
	localparam int CNT_W = 5;

	localparam logic [ADDR_W-1:0] REG_ENABLES   = 7'h01;
	localparam logic [ADDR_W-1:0] REG_INT_MODE  = 7'h02;
	localparam logic [ADDR_W-1:0] REG_FRAC_NUM  = 7'h03;
	localparam logic [ADDR_W-1:0] REG_FRAC_MOD  = 7'h04;
	localparam logic [ADDR_W-1:0] REG_REF_DIV   = 7'h20;
	localparam logic [ADDR_W-1:0] REG_STATUS_SEL = 7'h21;
	localparam logic [ADDR_W-1:0] REG_OSC_OUT   = 7'h22;
	localparam logic [ADDR_W-1:0] REG_STATE     = 7'h23;
	localparam logic [ADDR_W-1:0] REG_TUNE_DAC  = 7'h49;

	localparam logic [DATA_W-1:0] RST_ENABLES    = 16'h0000;
	localparam logic [DATA_W-1:0] RST_INT_MODE   = 16'h0058;
	localparam logic [DATA_W-1:0] RST_FRAC_NUM   = 16'h0000;
	localparam logic [DATA_W-1:0] RST_FRAC_MOD   = 16'h0001;
	localparam logic [DATA_W-1:0] RST_REF_DIV    = 16'h0001;
	localparam logic [DATA_W-1:0] RST_STATUS_SEL = 16'h0000;
	localparam logic [DATA_W-1:0] RST_OSC_OUT    = 16'h0000;
	localparam logic [DATA_W-1:0] RST_TUNE_DAC   = 16'h0000;

	localparam int BIT_LO_BUF_ON = 7;
	localparam int BIT_INT_MODE  = 15;
	localparam int OSC_LSB = 0;
	localparam int OSC_W   = 3;
	localparam int ODIV_LSB = 3;
	localparam int ODIV_W   = 3;
	localparam int AMP_LSB = 6;
	localparam int AMP_W   = 2;
	localparam int SEL_LSB = 13;
	localparam int SEL_W   = 2;
	localparam int REF_W   = 13;
	localparam int DAC_BASE_W = 9;
	localparam int DAC_GRAD_LSB = 9;
	localparam int DAC_GRAD_W = 5;
	localparam int STATE_W = 2;

	localparam logic [SEL_W-1:0] SRC_LOCK   = 2'h0;
	localparam logic [SEL_W-1:0] SRC_CAL    = 2'h1;
	localparam logic [SEL_W-1:0] SRC_CMP    = 2'h2;

	localparam int CAL_CMP_CYCLES = 5120;
	localparam int CAL_W = 13;

	typedef enum logic [1:0] {
		CAL_IDLE,
		CAL_RUN,
		CAL_SETTLE
	} pscc_cal_t;
endpackage
`default_nettype wire

/* File: design/pscc_ref_divider.sv */
/*
 * Reference divider: counts rising edges of the reference input and gives one
 * comparison tick every ref_divide edges.
 * Assumes ref_clk_in is slow against mclk and synchronous to it.
 */
`timescale 1ns/1ps
`default_nettype none
module pscc_ref_divider
	import pscc_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic             ref_clk_in,
	input  wire logic [REF_W-1:0] ref_divide,
	output var  logic             cmp_tick
);
	logic             ref_prev_q;
	logic             ref_prev_d;
	logic [REF_W-1:0] cnt_q;
	logic [REF_W-1:0] cnt_d;
	logic             tick_q;
	logic             tick_d;
	logic [REF_W-1:0] last;

	always_comb begin
		ref_prev_d = ref_clk_in;
		cnt_d = cnt_q;
		tick_d = 1'b0;
		// zero treated as divide by one
		last = (ref_divide == '0) ? '0 : ref_divide - REF_W'(1);
		if (ref_clk_in && !ref_prev_q) begin
			if (cnt_q >= last) begin
				cnt_d = '0;
				tick_d = 1'b1;
			end else begin
				cnt_d = cnt_q + REF_W'(1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ref_prev_q <= 1'b0;
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_prev_d;
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign cmp_tick = tick_q;

	chk_tick_single: assert property (@(posedge mclk) disable iff (!rstn)
		cmp_tick |=> !cmp_tick)
		else $error("comparison tick lasted more than one cycle");
endmodule
`default_nettype wire

/* File: design/pscc_synth_ctrl.sv */
/*
 * Synthesizer control: 3-wire serial register port, divider and oscillator
 * settings, band calibration sequencer, lock and status pin routing.
 * Assumes sclk, cs_n, sdio and the analog lock level are synchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module pscc_synth_ctrl
	import pscc_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_CMP_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	input  wire logic                  sclk,
	input  wire logic                  cs_n,
	input  wire logic                  sdio_in,
	output var  logic                  sdio_out,
	output var  logic                  sdio_oe,
	input  wire logic                  ref_clk_in,
	input  wire logic                  loop_lock_in,
	output var  logic [OSC_W-1:0]      oscillator_choice,
	output var  logic                  divider_integer_mode,
	output var  logic [DATA_W-2:0]     feedback_integer,
	output var  logic [DATA_W-1:0]     feedback_numerator,
	output var  logic [DATA_W-1:0]     feedback_modulus,
	output var  logic [ODIV_W-1:0]     output_divide_code,
	output var  logic [REF_W-1:0]      ref_divide,
	output var  logic                  lo_buffer_on,
	output var  logic [AMP_W-1:0]      lo_buffer_amplitude,
	output var  logic [DAC_GRAD_W-1:0] tuning_dac_gradient,
	output var  logic [DAC_BASE_W-1:0] tuning_dac_base,
	output var  logic                  band_cal_active,
	output var  logic                  status_mux_pin
);
	// serial port
	logic                  sclk_prev_q, sclk_prev_d;
	logic [CNT_W-1:0]      bit_cnt_q, bit_cnt_d;
	logic [FRAME_BITS-1:0] shin_q, shin_d;
	logic [DATA_W-1:0]     shout_q, shout_d;
	logic                  rd_q, rd_d;
	logic                  sdo_q, sdo_d;
	logic                  oe_q, oe_d;
	logic                  wr_q, wr_d;
	logic [ADDR_W-1:0]     wr_addr_q, wr_addr_d;
	logic [DATA_W-1:0]     wr_data_q, wr_data_d;
	logic                  sclk_rise, sclk_fall;
	logic [ADDR_W-1:0]     hdr_addr;

	// registers
	logic [DATA_W-1:0] en_q, en_d, int_q, int_d, num_q, num_d, mod_q, mod_d;
	logic [DATA_W-1:0] refd_q, refd_d, sel_q, sel_d, osc_q, osc_d, dac_q, dac_d;

	// calibration and lock
	pscc_cal_t         cal_q, cal_d;
	logic [CAL_W-1:0]  cal_cnt_q, cal_cnt_d;
	logic              lock_q, lock_d;
	logic              mux_q, mux_d;
	logic              cal_run_q, cal_run_d;
	logic              cmp_tick;
	logic              cmp_lvl_q, cmp_lvl_d;
	logic              fb_write;

	pscc_ref_divider i_pscc_ref_divider (
		.mclk       (mclk),
		.rstn       (rstn),
		.ref_clk_in (ref_clk_in),
		.ref_divide (refd_q[REF_W-1:0]),
		.cmp_tick   (cmp_tick)
	);

	function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] v;
		v = '0;
		case (a)
			REG_ENABLES:    v = en_q;
			REG_INT_MODE:   v = int_q;
			REG_FRAC_NUM:   v = num_q;
			REG_FRAC_MOD:   v = mod_q;
			REG_REF_DIV:    v = refd_q;
			REG_STATUS_SEL: v = sel_q;
			REG_OSC_OUT:    v = osc_q;
			REG_STATE:      v = {{(DATA_W-STATE_W){1'b0}}, lock_q, band_cal_active};
			REG_TUNE_DAC:   v = dac_q;
			default:        v = '0;
		endcase
		return v;
	endfunction

	assign sclk_rise = sclk && !sclk_prev_q;
	assign sclk_fall = !sclk && sclk_prev_q;
	assign hdr_addr = {shin_q[ADDR_W-2:0], sdio_in};

	// frame: r/w bit, 7 address bits, 16 data bits, msb first
	always_comb begin
		sclk_prev_d = sclk;
		bit_cnt_d = bit_cnt_q;
		shin_d = shin_q;
		shout_d = shout_q;
		rd_d = rd_q;
		sdo_d = sdo_q;
		oe_d = oe_q;
		wr_d = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_data_d = wr_data_q;
		if (cs_n) begin
			bit_cnt_d = '0;
			rd_d = 1'b0;
			oe_d = 1'b0;
		end else if (sclk_rise && bit_cnt_q < CNT_W'(FRAME_BITS)) begin
			shin_d = {shin_q[FRAME_BITS-2:0], sdio_in};
			bit_cnt_d = bit_cnt_q + CNT_W'(1);
			if (bit_cnt_q == CNT_W'(HDR_BITS - 1) && shin_q[ADDR_W-1]) begin
				rd_d = 1'b1;
				shout_d = read_value(hdr_addr);
			end
			if (bit_cnt_q == CNT_W'(FRAME_BITS - 1) && !shin_q[FRAME_BITS-2]) begin
				wr_d = 1'b1;
				wr_addr_d = shin_q[FRAME_BITS-3:DATA_W-1];
				wr_data_d = {shin_q[DATA_W-2:0], sdio_in};
			end
		end else if (sclk_fall && rd_q && bit_cnt_q < CNT_W'(FRAME_BITS)) begin
			sdo_d = shout_q[DATA_W-1];
			shout_d = {shout_q[DATA_W-2:0], 1'b0};
			oe_d = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_q <= 1'b0;
			bit_cnt_q <= '0;
			shin_q <= '0;
			shout_q <= '0;
			rd_q <= 1'b0;
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
			wr_q <= 1'b0;
			wr_addr_q <= '0;
			wr_data_q <= '0;
		end else begin
			sclk_prev_q <= sclk_prev_d;
			bit_cnt_q <= bit_cnt_d;
			shin_q <= shin_d;
			shout_q <= shout_d;
			rd_q <= rd_d;
			sdo_q <= sdo_d;
			oe_q <= oe_d;
			wr_q <= wr_d;
			wr_addr_q <= wr_addr_d;
			wr_data_q <= wr_data_d;
		end
	end

	always_comb begin
		en_d = en_q;
		int_d = int_q;
		num_d = num_q;
		mod_d = mod_q;
		refd_d = refd_q;
		sel_d = sel_q;
		osc_d = osc_q;
		dac_d = dac_q;
		if (wr_q) begin
			case (wr_addr_q)
				REG_ENABLES:    en_d = wr_data_q;
				REG_INT_MODE:   int_d = wr_data_q;
				REG_FRAC_NUM:   num_d = wr_data_q;
				REG_FRAC_MOD:   mod_d = wr_data_q;
				REG_REF_DIV:    refd_d = wr_data_q & {{(DATA_W-REF_W){1'b0}}, {REF_W{1'b1}}};
				REG_STATUS_SEL: sel_d = wr_data_q;
				REG_OSC_OUT:    osc_d = wr_data_q;
				REG_TUNE_DAC:   dac_d = wr_data_q;
				default:        en_d = en_q;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			en_q <= RST_ENABLES;
			int_q <= RST_INT_MODE;
			num_q <= RST_FRAC_NUM;
			mod_q <= RST_FRAC_MOD;
			refd_q <= RST_REF_DIV;
			sel_q <= RST_STATUS_SEL;
			osc_q <= RST_OSC_OUT;
			dac_q <= RST_TUNE_DAC;
		end else begin
			en_q <= en_d;
			int_q <= int_d;
			num_q <= num_d;
			mod_q <= mod_d;
			refd_q <= refd_d;
			sel_q <= sel_d;
			osc_q <= osc_d;
			dac_q <= dac_d;
		end
	end

	assign fb_write = wr_q && (wr_addr_q == REG_INT_MODE || wr_addr_q == REG_FRAC_NUM
		|| wr_addr_q == REG_FRAC_MOD);

	// calibration, then settling, then lock; a new divider write restarts it
	always_comb begin
		cal_d = cal_q;
		cal_cnt_d = cal_cnt_q;
		cmp_lvl_d = cmp_tick ? !cmp_lvl_q : cmp_lvl_q;
		if (fb_write) begin
			cal_d = CAL_RUN;
			cal_cnt_d = '0;
		end else begin
			case (cal_q)
				CAL_IDLE: cal_d = CAL_IDLE;
				CAL_RUN: begin
					if (cmp_tick) begin
						if (cal_cnt_q == CAL_W'(CAL_CYCLES - 1)) begin
							cal_d = CAL_SETTLE;
						end else begin
							cal_cnt_d = cal_cnt_q + CAL_W'(1);
						end
					end
				end
				CAL_SETTLE: begin
					if (loop_lock_in) begin
						cal_d = CAL_IDLE;
					end
				end
				default: cal_d = CAL_IDLE;
			endcase
		end
		lock_d = (cal_d == CAL_IDLE) && loop_lock_in;
		cal_run_d = (cal_d == CAL_RUN);
		// new select steers the pin's very next value
		case (sel_d[SEL_LSB +: SEL_W])
			SRC_LOCK: mux_d = lock_d;
			SRC_CAL:  mux_d = cal_run_d;
			SRC_CMP:  mux_d = cmp_lvl_d;
			default:  mux_d = 1'b0;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cal_q <= CAL_IDLE;
			cal_cnt_q <= '0;
			lock_q <= 1'b0;
			mux_q <= 1'b0;
			cal_run_q <= 1'b0;
			cmp_lvl_q <= 1'b0;
		end else begin
			cal_q <= cal_d;
			cal_cnt_q <= cal_cnt_d;
			lock_q <= lock_d;
			mux_q <= mux_d;
			cal_run_q <= cal_run_d;
			cmp_lvl_q <= cmp_lvl_d;
		end
	end

	assign sdio_out = sdo_q;
	assign sdio_oe = oe_q;
	assign oscillator_choice = osc_q[OSC_LSB +: OSC_W];
	assign divider_integer_mode = int_q[BIT_INT_MODE];
	// words feed the feedback divider after the fixed x2 prescaler
	assign feedback_integer = int_q[DATA_W-2:0];
	assign feedback_numerator = num_q;
	assign feedback_modulus = mod_q;
	assign output_divide_code = osc_q[ODIV_LSB +: ODIV_W];
	assign ref_divide = refd_q[REF_W-1:0];
	assign lo_buffer_on = en_q[BIT_LO_BUF_ON];
	assign lo_buffer_amplitude = osc_q[AMP_LSB +: AMP_W];
	assign tuning_dac_gradient = dac_q[DAC_GRAD_LSB +: DAC_GRAD_W];
	assign tuning_dac_base = dac_q[DAC_BASE_W-1:0];
	assign band_cal_active = cal_run_q;
	assign status_mux_pin = mux_q;

	sequence s_fb_write;
		fb_write;
	endsequence
	sequence s_cal_start;
		band_cal_active && !lock_q;
	endsequence

	chk_cal_starts: assert property (@(posedge mclk) disable iff (!rstn)
		s_fb_write |=> s_cal_start)
		else $error("divider write did not start calibration");
	chk_lock_low: assert property (@(posedge mclk) disable iff (!rstn)
		(cal_q != CAL_IDLE) |-> !lock_q)
		else $error("lock shown during calibration or settling");
	chk_cal_end: assert property (@(posedge mclk) disable iff (!rstn)
		(cal_q == CAL_RUN && cmp_tick && !fb_write
			&& cal_cnt_q == CAL_W'(CAL_CYCLES - 1)) |=> (cal_q == CAL_SETTLE))
		else $error("calibration did not end after full count");
	chk_cal_hold: assert property (@(posedge mclk) disable iff (!rstn)
		(cal_q == CAL_RUN && cal_cnt_q < CAL_W'(CAL_CYCLES - 1) && !fb_write)
			|=> (cal_q == CAL_RUN))
		else $error("calibration ended early");
	chk_mux_lock: assert property (@(posedge mclk) disable iff (!rstn)
		(sel_q[SEL_LSB +: SEL_W] == SRC_LOCK) |-> (status_mux_pin == lock_q))
		else $error("status pin does not follow lock");
	chk_mode_write: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_q && wr_addr_q == REG_INT_MODE) |=>
			(divider_integer_mode == $past(wr_data_q[BIT_INT_MODE])))
		else $error("divider mode bit not taken");
	chk_osc_write: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_q && wr_addr_q == REG_OSC_OUT) |=>
			(oscillator_choice == $past(wr_data_q[OSC_W-1:0])))
		else $error("oscillator choice not taken");
	chk_lo_buffer: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_q && wr_addr_q == REG_ENABLES) |=>
			(lo_buffer_on == $past(wr_data_q[BIT_LO_BUF_ON])))
		else $error("lo buffer enable not taken");
	chk_lo_amp: assert property (@(posedge mclk) disable iff (!rstn)
		(wr_q && wr_addr_q == REG_OSC_OUT) |=>
			(lo_buffer_amplitude == $past(wr_data_q[AMP_LSB+1:AMP_LSB])))
		else $error("lo amplitude not taken");
endmodule
`default_nettype wire

/* File: testbench/pscc_host_model.sv */
/*
 * Host controller model: sends 3-wire serial frames to the synthesizer control
 * block and collects read data from the shared data line.
 * Assumes mclk is the block's clock and the bench resolves the data line.
 */
`timescale 1ns/1ps
`default_nettype none
module pscc_host_model (
	input  wire logic mclk,
	input  wire logic sdio_line,
	output var  logic sclk,
	output var  logic cs_n,
	output var  logic host_sdio,
	output var  logic host_oe
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		host_sdio = 1'b0;
		host_oe = 1'b0;
	end

	// r/w bit, 7 address bits, 16 data bits, msb first; serial clock idles low
	task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] wd,
		output logic [15:0] rq);
		logic [23:0] fr;
		fr = {rd, addr, wd};
		rq = 16'h0000;
		@(posedge mclk);
		cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sclk <= 1'b0;
			host_oe <= !(rd && i < 16);
			host_sdio <= fr[i];
			repeat (4) @(posedge mclk);
			sclk <= 1'b1;
			if (rd && i < 16) begin
				rq[i] = sdio_line;
			end
			repeat (4) @(posedge mclk);
		end
		cs_n <= 1'b1;
		sclk <= 1'b0;
		host_oe <= 1'b0;
		@(posedge mclk);
	endtask
endmodule
`default_nettype wire

/* File: testbench/pscc_synth_ctrl_test.sv */
/*
 * Self-checking bench for the synthesizer control block: register writes and
 * reads through the host model, field outputs, calibration and status pin.
 * Assumes the design package and both design modules are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module pscc_synth_ctrl_test;
	import pscc_pkg::*;
	localparam int CALN = 4;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic ref_clk_in = 1'b0;
	logic loop_lock_in = 1'b0;
	logic [2:0] ref_cnt = 3'h0;
	logic pin_seen;
	logic sclk, cs_n, host_sdio, host_oe, sdio_out, sdio_oe, sdio_line;
	logic [OSC_W-1:0] oscillator_choice;
	logic divider_integer_mode, lo_buffer_on, band_cal_active, status_mux_pin;
	logic [DATA_W-2:0] feedback_integer;
	logic [DATA_W-1:0] feedback_numerator, feedback_modulus;
	logic [ODIV_W-1:0] output_divide_code;
	logic [REF_W-1:0] ref_divide;
	logic [AMP_W-1:0] lo_buffer_amplitude;
	logic [DAC_GRAD_W-1:0] tuning_dac_gradient;
	logic [DAC_BASE_W-1:0] tuning_dac_base;
	int bad_count = 0;
	int comparisons = 0;

	always #2.5 mclk = ~mclk;
	// reference input with a period of 8 mclk
	always @(posedge mclk) begin
		ref_cnt <= ref_cnt + 3'h1;
		ref_clk_in <= ref_cnt[2];
	end
	// undriven line shows the inverse of the host's last bit
	assign sdio_line = sdio_oe ? sdio_out : (host_oe ? host_sdio : ~host_sdio);

	pscc_host_model i_pscc_host_model (
		.mclk(mclk), .sdio_line(sdio_line), .sclk(sclk), .cs_n(cs_n),
		.host_sdio(host_sdio), .host_oe(host_oe)
	);

	pscc_synth_ctrl #(.CAL_CYCLES(CALN)) i_pscc_synth_ctrl (
		.mclk(mclk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_line),
		.sdio_out(sdio_out), .sdio_oe(sdio_oe), .ref_clk_in(ref_clk_in),
		.loop_lock_in(loop_lock_in), .oscillator_choice(oscillator_choice),
		.divider_integer_mode(divider_integer_mode), .feedback_integer(feedback_integer),
		.feedback_numerator(feedback_numerator), .feedback_modulus(feedback_modulus),
		.output_divide_code(output_divide_code), .ref_divide(ref_divide),
		.lo_buffer_on(lo_buffer_on), .lo_buffer_amplitude(lo_buffer_amplitude),
		.tuning_dac_gradient(tuning_dac_gradient), .tuning_dac_base(tuning_dac_base),
		.band_cal_active(band_cal_active), .status_mux_pin(status_mux_pin)
	);

	task automatic stop_test();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] q;
		i_pscc_host_model.xfer(1'b0, a, d, q);
		#1;
	endtask

	task automatic rd(input logic [6:0] a, input logic [15:0] e, input string n);
		logic [15:0] q;
		i_pscc_host_model.xfer(1'b1, a, 16'h0000, q);
		#1;
		check(n, e, q);
	endtask

	// waits out a calibration and checks its length in mclk cycles
	task automatic cal_chk(input int p);
		int n;
		n = 0;
		while (band_cal_active === 1'b1 && n < 20000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n >= 20000) begin
			bad_count++;
			stop_test();
		end
		check("cal length ok", 16'h0001, 16'((n >= (CALN - 1) * p - 8) && (n <= CALN * p + 4)));
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		#1;
		check("integer mode", 16'h0000, 16'(divider_integer_mode));
		check("integer", 16'h0058, 16'(feedback_integer));
		check("modulus", 16'h0001, feedback_modulus);
		rd(REG_STATUS_SEL, 16'h0000, "status select");
		rd(REG_INT_MODE, 16'h0058, "integer reg");
		for (int i = 0; i < 4; i++) begin
			wr(REG_OSC_OUT, 16'((i << 6) | (i << 3) | i));
			check("oscillator", 16'(i), 16'(oscillator_choice));
			check("out divide", 16'(i), 16'(output_divide_code));
			check("amplitude", 16'(i), 16'(lo_buffer_amplitude));
			check("no cal", 16'h0000, 16'(band_cal_active));
		end
		rd(REG_OSC_OUT, 16'h00db, "osc reg");
		wr(REG_ENABLES, 16'h0080);
		check("lo buffer", 16'h0001, 16'(lo_buffer_on));
		wr(REG_TUNE_DAC, 16'h16b8);
		check("dac gradient", 16'h000b, 16'(tuning_dac_gradient));
		check("dac base", 16'h00b8, 16'(tuning_dac_base));
		wr(REG_REF_DIV, 16'h1fff);
		check("ref divide", 16'h1fff, 16'(ref_divide));
		wr(REG_REF_DIV, 16'h0002);
		rd(7'h7f, 16'h0000, "unmapped");
		wr(REG_FRAC_NUM, 16'hffff);
		check("numerator", 16'hffff, feedback_numerator);
		check("cal start", 16'h0001, 16'(band_cal_active));
		cal_chk(16);
		repeat (10) @(posedge mclk);
		#1;
		check("settling pin", 16'h0000, 16'(status_mux_pin));
		@(posedge mclk);
		loop_lock_in <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		check("lock pin", 16'h0001, 16'(status_mux_pin));
		wr(REG_REF_DIV, 16'h0001);
		wr(REG_FRAC_MOD, 16'ha5c3);
		check("modulus", 16'ha5c3, feedback_modulus);
		check("cal start", 16'h0001, 16'(band_cal_active));
		check("lock in cal", 16'h0000, 16'(status_mux_pin));
		cal_chk(8);
		wr(REG_STATUS_SEL, 16'h2000);
		wr(REG_INT_MODE, 16'h8123);
		check("integer mode", 16'h0001, 16'(divider_integer_mode));
		check("integer", 16'h0123, 16'(feedback_integer));
		check("cal source pin", 16'h0001, 16'(status_mux_pin));
		cal_chk(8);
		#5;
		check("cal source idle", 16'h0000, 16'(status_mux_pin));
		wr(REG_STATUS_SEL, 16'h4000);
		pin_seen = status_mux_pin;
		repeat (8) @(posedge mclk);
		#1;
		check("comparison pin", 16'(!pin_seen), 16'(status_mux_pin));
		wr(REG_STATUS_SEL, 16'h6000);
		check("low source", 16'h0000, 16'(status_mux_pin));
		wr(REG_STATUS_SEL, 16'h0000);
		check("lock source", 16'h0001, 16'(status_mux_pin));
		rd(REG_FRAC_MOD, 16'ha5c3, "modulus reg");
		stop_test();
	end
endmodule
`default_nettype wire
